//--- core/fepc_top.sv
// Purpose: 100 Mbps coding sublayer: 4B/5B, delimiters, scrambling, link monitor
// Assumes: One 50 MHz clock, bit rate one bit per clock, APB register access
// Notes:   Symbol period is five clocks; nibble strobe marks each symbol
`timescale 1ns/1ns
`default_nettype none
`include "fepc_consts.svh"
module fepc_top #(
    parameter int unsigned CNT_W        = 20,
    parameter int unsigned ASSERT_CYC   = `FEPC_ASSERT_US * `FEPC_CLK_MHZ,
    parameter int unsigned DEASSERT_CYC = `FEPC_DEASSERT_US * `FEPC_CLK_MHZ
) (
    input  wire logic        sys_clk,
    input  wire logic        rst_b,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        tx_en,
    input  wire logic        tx_er,
    input  wire logic [3:0]  txd,
    output logic             nibble_strobe,
    output logic [3:0]       rxd,
    output logic             rx_dv,
    output logic             rx_er,
    output logic             crs,
    output logic             col,
    input  wire logic        line_rx_in,
    output logic             line_tx_out,
    input  wire logic        line_energy_in,
    input  wire logic        fiber_energy_input,
    input  wire logic        coding_bypass_strap,
    input  wire logic [4:0]  mgmt_addr_strap,
    output logic             energy_present_flag,
    output logic             link_ok
);
    import fepc_pkg::*;

    // ----------------------------------------
    // Code-group tables
    // ----------------------------------------
    function automatic logic [4:0] enc(input logic [3:0] n);
        logic [4:0] c;
        c = 5'h00;
        case (n)
            4'h0: c = 5'h1E;
            4'h1: c = 5'h09;
            4'h2: c = 5'h14;
            4'h3: c = 5'h15;
            4'h4: c = 5'h0A;
            4'h5: c = 5'h0B;
            4'h6: c = 5'h0E;
            4'h7: c = 5'h0F;
            4'h8: c = 5'h12;
            4'h9: c = 5'h13;
            4'hA: c = 5'h16;
            4'hB: c = 5'h17;
            4'hC: c = 5'h1A;
            4'hD: c = 5'h1B;
            4'hE: c = 5'h1C;
            default: c = 5'h1D;
        endcase
        return c;
    endfunction

    // Returns valid flag and nibble; undefined codes are invalid
    function automatic logic [4:0] dec(input logic [4:0] s);
        logic [4:0] r;
        r = 5'h00;
        for (int i = 0; i < 16; i++) begin
            if (enc(4'(i)) == s) begin
                r = {1'b1, 4'(i)};
            end
        end
        return r;
    endfunction

    // ----------------------------------------
    // Pin synchronisers and strap capture
    // ----------------------------------------
    logic [8:0] pin_s1_reg;
    logic [8:0] pin_s2_reg;
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            pin_s1_reg <= 9'h000;
            pin_s2_reg <= 9'h000;
        end else begin
            pin_s1_reg <= {mgmt_addr_strap, coding_bypass_strap, fiber_energy_input,
                           line_energy_in, line_rx_in};
            pin_s2_reg <= pin_s1_reg;
        end
    end
    wire logic       rx_pin_s    = pin_s2_reg[0];
    wire logic       cu_energy_s = pin_s2_reg[1];
    wire logic       fx_energy_s = pin_s2_reg[2];
    wire logic       strap_bp_s  = pin_s2_reg[3];
    wire logic [4:0] addr_s      = pin_s2_reg[8:4];

    logic [1:0] boot_reg;
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            boot_reg <= 2'h0;
        end else if (boot_reg != `FEPC_BOOT_LAST) begin
            boot_reg <= boot_reg + 2'h1;
        end
    end
    wire logic seed_load = (boot_reg == `FEPC_BOOT_LAST - 2'h1);

    // ----------------------------------------
    // APB registers
    // ----------------------------------------
    logic loc_lb_reg;
    logic fiber_reg;
    logic bypass_reg;
    logic noscr_reg;
    logic rem_lb_reg;
    logic pready_reg;
    logic pslverr_reg;
    logic [31:0] prdata_reg;
    logic link_ok_reg;
    logic energy_reg;
    logic aligned_reg;
    logic rx_active_reg;

    wire logic hit_c0   = (paddr == `FEPC_OFF_CTRL0);
    wire logic hit_c21  = (paddr == `FEPC_OFF_CTRL21);
    wire logic hit_st   = (paddr == `FEPC_OFF_STATUS);
    wire logic hit      = hit_c0 | hit_c21 | hit_st;
    wire logic access   = psel & penable & ~pready_reg;
    wire logic wr_fire  = psel & penable & pwrite & pready_reg;
    wire logic bypass_on = bypass_reg | strap_bp_s;
    wire logic scr_on    = ~fiber_reg & ~noscr_reg;
    wire logic [31:0] rd_c0  = 32'(loc_lb_reg) << `FEPC_LOOP_BIT;
    wire logic [31:0] rd_c21 = (32'(fiber_reg) << `FEPC_FIBER_BIT)
                             | (32'(bypass_reg) << `FEPC_BYPASS_BIT)
                             | (32'(noscr_reg) << `FEPC_NOSCR_BIT)
                             | (32'(rem_lb_reg) << `FEPC_RLOOP_BIT);
    wire logic [31:0] rd_st  = {27'h0, bypass_on, rx_active_reg, aligned_reg,
                                energy_reg, link_ok_reg};
    wire logic [31:0] rd_val = hit_c0 ? rd_c0 : hit_c21 ? rd_c21 : hit_st ? rd_st : 32'h0;

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            pready_reg  <= 1'b0;
            pslverr_reg <= 1'b0;
            prdata_reg  <= 32'h0;
        end else begin
            pready_reg  <= access;
            pslverr_reg <= access & ~hit;
            prdata_reg  <= access ? rd_val : 32'h0;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            loc_lb_reg <= 1'b0;
            fiber_reg  <= 1'b0;
            bypass_reg <= 1'b0;
            noscr_reg  <= 1'b0;
            rem_lb_reg <= 1'b0;
        end else if (wr_fire && hit_c0) begin
            loc_lb_reg <= pwdata[`FEPC_LOOP_BIT];
        end else if (wr_fire && hit_c21) begin
            fiber_reg  <= pwdata[`FEPC_FIBER_BIT];
            bypass_reg <= pwdata[`FEPC_BYPASS_BIT];
            noscr_reg  <= pwdata[`FEPC_NOSCR_BIT];
            rem_lb_reg <= pwdata[`FEPC_RLOOP_BIT];
        end
    end

    // ----------------------------------------
    // Energy detect and link monitor
    // ----------------------------------------
    logic [CNT_W-1:0] en_cnt_reg;
    fepc_link_state_type link_reg;
    wire logic en_src = fiber_reg ? fx_energy_s : cu_energy_s;
    wire logic en_hit = energy_reg
                      ? (en_cnt_reg == CNT_W'(DEASSERT_CYC - 1))
                      : (en_cnt_reg == CNT_W'(ASSERT_CYC));
    wire logic link_up = (link_reg == LINK_PASS);

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            en_cnt_reg <= '0;
            energy_reg <= 1'b0;
        end else if (en_src == energy_reg) begin
            en_cnt_reg <= '0;
        end else if (en_hit) begin
            en_cnt_reg <= '0;
            energy_reg <= ~energy_reg;
        end else begin
            en_cnt_reg <= en_cnt_reg + CNT_W'(1);
        end
    end

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            link_reg    <= LINK_FAIL;
            link_ok_reg <= 1'b0;
        end else begin
            link_reg    <= energy_reg ? LINK_PASS : LINK_FAIL;
            link_ok_reg <= rem_lb_reg | (~loc_lb_reg & link_up);
        end
    end

    // ----------------------------------------
    // Transmit: encoder, scrambler, NRZI
    // ----------------------------------------
    fepc_tx_state_type tx_state_reg;
    fepc_tx_state_type tx_state_next;
    logic [2:0]  tx_cnt_reg;
    logic [4:0]  tx_sh_reg;
    logic [4:0]  tx_cg_reg;
    logic [10:0] tx_lfsr_reg;
    logic        line_tx_reg;
    logic        strobe_reg;
    logic [4:0]  cg_next;

    wire logic tx_load = (tx_cnt_reg == `FEPC_SYM_LAST);
    wire logic tx_key  = tx_lfsr_reg[10] ^ tx_lfsr_reg[8];
    wire logic tx_bit  = tx_sh_reg[4] ^ (scr_on & tx_key);
    wire logic tx_busy = (tx_state_reg != TX_IDLE) | (tx_cg_reg != `FEPC_CG_IDLE);

    always_comb begin
        tx_state_next = TX_IDLE;
        case (tx_state_reg)
            TX_IDLE: tx_state_next = (tx_en && link_up && !bypass_on) ? TX_J : TX_IDLE;
            TX_J:    tx_state_next = TX_K;
            TX_K:    tx_state_next = tx_en ? TX_DATA : TX_T;
            TX_DATA: tx_state_next = tx_en ? TX_DATA : TX_T;
            TX_T:    tx_state_next = TX_R;
            TX_R:    tx_state_next = TX_IDLE;
            default: tx_state_next = TX_IDLE;
        endcase
    end

    always_comb begin
        cg_next = `FEPC_CG_IDLE;
        if (!link_up) begin
            cg_next = `FEPC_CG_IDLE;
        end else if (bypass_on) begin
            cg_next = tx_en ? {tx_er, txd} : `FEPC_CG_IDLE;
        end else begin
            case (tx_state_next)
                TX_J:    cg_next = `FEPC_CG_J;
                TX_K:    cg_next = `FEPC_CG_K;
                TX_DATA: cg_next = tx_er ? `FEPC_CG_H : enc(txd);
                TX_T:    cg_next = `FEPC_CG_T;
                TX_R:    cg_next = `FEPC_CG_R;
                default: cg_next = `FEPC_CG_IDLE;
            endcase
        end
    end

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            tx_cnt_reg   <= 3'h0;
            tx_state_reg <= TX_IDLE;
            tx_sh_reg    <= `FEPC_CG_IDLE;
            tx_cg_reg    <= `FEPC_CG_IDLE;
            strobe_reg   <= 1'b0;
        end else begin
            tx_cnt_reg <= tx_load ? 3'h0 : tx_cnt_reg + 3'h1;
            strobe_reg <= (tx_cnt_reg == `FEPC_SYM_LAST - 3'h2);
            if (tx_load) begin
                tx_state_reg <= link_up ? tx_state_next : TX_IDLE;
                tx_sh_reg    <= cg_next;
                tx_cg_reg    <= cg_next;
            end else begin
                tx_sh_reg <= {tx_sh_reg[3:0], 1'b0};
            end
        end
    end

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            tx_lfsr_reg <= 11'h000;
            line_tx_reg <= 1'b0;
        end else begin
            tx_lfsr_reg <= seed_load ? {`FEPC_SEED_TOP, addr_s}
                                     : {tx_lfsr_reg[9:0], tx_key};
            line_tx_reg <= line_tx_reg ^ tx_bit;
        end
    end

    // ----------------------------------------
    // Receive: NRZI, descrambler, alignment, decoder
    // ----------------------------------------
    logic        rx_prev_reg;
    logic [10:0] rx_lfsr_reg;
    logic        lock_reg;
    logic [4:0]  run_reg;
    logic [9:0]  rx_sh_reg;
    logic [2:0]  rx_cnt_reg;
    logic        t_seen_reg;
    logic [3:0]  rxd_reg;
    logic        rx_dv_reg;
    logic        rx_er_reg;
    logic        crs_reg;
    logic        col_reg;

    wire logic       rx_nrz   = rx_pin_s ^ rx_prev_reg;
    wire logic       rx_key   = rx_lfsr_reg[10] ^ rx_lfsr_reg[8];
    wire logic       rx_plain = rx_nrz ^ (scr_on & rx_key);
    wire logic       lfsr_in  = lock_reg ? rx_key : ~rx_nrz;
    wire logic       jk_found = ~aligned_reg & (rx_sh_reg == `FEPC_JK_PAIR);
    wire logic       sym_done = aligned_reg & (rx_cnt_reg == `FEPC_SYM_LAST);
    wire logic [4:0] rx_sym   = rx_sh_reg[4:0];
    wire logic [4:0] rx_dec   = dec(rx_sym);

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            rx_prev_reg <= 1'b0;
            rx_lfsr_reg <= 11'h000;
            lock_reg    <= 1'b0;
            run_reg     <= 5'h00;
            rx_sh_reg   <= 10'h000;
        end else begin
            rx_prev_reg <= rx_pin_s;
            rx_lfsr_reg <= {rx_lfsr_reg[9:0], lfsr_in};
            rx_sh_reg   <= {rx_sh_reg[8:0], rx_plain};
            run_reg     <= rx_plain ? ((run_reg == `FEPC_LOCK_RUN) ? run_reg
                                       : run_reg + 5'h01) : 5'h00;
            lock_reg    <= link_up & (lock_reg | ~scr_on | (run_reg == `FEPC_LOCK_RUN));
        end
    end

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            aligned_reg   <= 1'b0;
            rx_active_reg <= 1'b0;
            rx_cnt_reg    <= 3'h0;
            t_seen_reg    <= 1'b0;
            rxd_reg       <= 4'h0;
            rx_dv_reg     <= 1'b0;
            rx_er_reg     <= 1'b0;
        end else begin
            rx_er_reg  <= 1'b0;
            rx_cnt_reg <= (sym_done || jk_found) ? 3'h0 : rx_cnt_reg + 3'h1;
            if (!link_up || !lock_reg) begin
                aligned_reg   <= 1'b0;
                rx_active_reg <= 1'b0;
                rx_dv_reg     <= 1'b0;
            end else if (jk_found) begin
                aligned_reg   <= 1'b1;
                rx_active_reg <= 1'b1;
                rxd_reg       <= `FEPC_SFD_NIB;
                rx_dv_reg     <= 1'b1;
            end else if (sym_done && t_seen_reg) begin
                t_seen_reg  <= 1'b0;
                aligned_reg <= 1'b0;
                rx_er_reg   <= (rx_sym != `FEPC_CG_R);
            end else if (sym_done && bypass_on) begin
                rxd_reg   <= rx_sym[3:0];
                rx_dv_reg <= 1'b1;
                if (rx_sym == `FEPC_CG_IDLE) begin
                    rx_active_reg <= 1'b0;
                    rx_dv_reg     <= 1'b0;
                    aligned_reg   <= 1'b0;
                end
            end else if (sym_done && rx_sym == `FEPC_CG_T) begin
                rx_active_reg <= 1'b0;
                rx_dv_reg     <= 1'b0;
                t_seen_reg    <= 1'b1;
            end else if (sym_done && rx_sym == `FEPC_CG_IDLE) begin
                rx_active_reg <= 1'b0;
                rx_dv_reg     <= 1'b0;
                aligned_reg   <= 1'b0;
                rx_er_reg     <= 1'b1;
            end else if (sym_done) begin
                rxd_reg   <= rx_dec[3:0];
                rx_dv_reg <= 1'b1;
                rx_er_reg <= ~rx_dec[4];
            end
        end
    end

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            crs_reg <= 1'b0;
            col_reg <= 1'b0;
        end else begin
            crs_reg <= tx_busy | rx_active_reg;
            col_reg <= tx_busy & rx_active_reg;
        end
    end

    // ----------------------------------------
    // Outputs
    // ----------------------------------------
    assign prdata              = prdata_reg;
    assign pready              = pready_reg;
    assign pslverr             = pslverr_reg;
    assign nibble_strobe       = strobe_reg;
    assign rxd                 = rxd_reg;
    assign rx_dv               = rx_dv_reg;
    assign rx_er               = rx_er_reg;
    assign crs                 = crs_reg;
    assign col                 = col_reg;
    assign line_tx_out         = line_tx_reg;
    assign energy_present_flag = energy_reg;
    assign link_ok             = link_ok_reg;

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    start_pair_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
        tx_load && tx_state_next == TX_J && link_up && !bypass_on
        |=> tx_cg_reg == `FEPC_CG_J ##5 tx_cg_reg == `FEPC_CG_K)
        else $error("start delimiter pair not sent");
    end_pair_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
        tx_load && link_up && tx_state_reg == TX_DATA && !tx_en
        |=> tx_cg_reg == `FEPC_CG_T ##5 tx_cg_reg == `FEPC_CG_R)
        else $error("end delimiter pair not sent");
    idle_fill_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
        tx_load && tx_state_reg == TX_IDLE && !tx_en |=> tx_cg_reg == `FEPC_CG_IDLE)
        else $error("idle fill missing");
    err_symbol_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
        tx_load && link_up && !bypass_on && tx_state_next == TX_DATA && tx_er
        |=> tx_cg_reg == `FEPC_CG_H)
        else $error("transmit error symbol missing");
    fail_idle_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
        tx_load && !link_up |=> tx_cg_reg == `FEPC_CG_IDLE)
        else $error("non-idle sent in link fail");
    local_loop_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
        loc_lb_reg && !rem_lb_reg |=> !link_ok_reg)
        else $error("link not low in local loopback");
    remote_loop_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
        rem_lb_reg |=> link_ok_reg)
        else $error("link not high in remote loopback");
    collision_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
        tx_busy && rx_active_reg |=> col_reg && crs_reg)
        else $error("collision not flagged");
    energy_rise_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
        $rose(energy_reg) |-> $past(en_src, 2) && $past(en_cnt_reg) == CNT_W'(ASSERT_CYC))
        else $error("energy flag rose early");
endmodule // fepc_top
`default_nettype wire

//--- common/fepc_consts.svh
// Purpose: Named constants for the 100 Mbps coding block
// Assumes: 50 MHz system clock
// Notes:   Offsets are byte addresses on the register bus
`ifndef FEPC_CONSTS_SVH
`define FEPC_CONSTS_SVH
// ----------------------------------------
// Register map
// ----------------------------------------
`define FEPC_OFF_CTRL0    8'h00
`define FEPC_OFF_STATUS   8'h04
`define FEPC_OFF_CTRL21   8'h54
`define FEPC_LOOP_BIT     14
`define FEPC_FIBER_BIT    0
`define FEPC_BYPASS_BIT   1
`define FEPC_NOSCR_BIT    2
`define FEPC_RLOOP_BIT    3
// ----------------------------------------
// Code-groups
// ----------------------------------------
`define FEPC_CG_IDLE      5'h1F
`define FEPC_CG_J         5'h18
`define FEPC_CG_K         5'h11
`define FEPC_CG_T         5'h0D
`define FEPC_CG_R         5'h07
`define FEPC_CG_H         5'h04
`define FEPC_JK_PAIR      10'h311
`define FEPC_SFD_NIB      4'h5
// ----------------------------------------
// Timing
// ----------------------------------------
`define FEPC_CLK_MHZ      50
`define FEPC_ASSERT_US    2000
`define FEPC_DEASSERT_US  1000
`define FEPC_SYM_LAST     3'h4
`define FEPC_LOCK_RUN     5'h1E
`define FEPC_BOOT_LAST    2'h3
`define FEPC_SEED_TOP     6'h20
`endif

//--- common/fepc_pkg.sv
// Purpose: Types for the 100 Mbps coding block
// Assumes: Nothing
// Notes:   Constants live in fepc_consts.svh
`default_nettype none
package fepc_pkg;
    typedef enum logic [2:0] {TX_IDLE, TX_J, TX_K, TX_DATA, TX_T, TX_R} fepc_tx_state_type;
    typedef enum logic {LINK_FAIL, LINK_PASS} fepc_link_state_type;
endpackage
`default_nettype wire

//--- testbench/fepc_mac_model.sv
// Purpose: MAC side model driving the MII transmit inputs
// Assumes: Nibble strobe paces each nibble
// Notes:   Sent nibbles are kept for the bench to compare
`timescale 1ns/1ns
`default_nettype none
module fepc_mac_model (
    input  wire logic       sys_clk,
    input  wire logic       nibble_strobe,
    output logic            tx_en,
    output logic            tx_er,
    output logic [3:0]      txd
);
    logic [3:0] sent[$];
    initial begin
        tx_en = 0;
        tx_er = 0;
        txd   = 4'h0;
    end
    // Preamble, start of frame, then n + 1 random data nibbles
    // Raw mode sends J and K as code-groups, for coding bypass
    task automatic send(input int n, input int er, input bit raw);
        logic [3:0] v;
        sent.delete();
        for (int i = 0; i < n + 9; i++) begin
            v = (i < 7) ? 4'h5 : (i == 7) ? 4'hD : 4'($urandom);
            do @(posedge sys_clk); while (nibble_strobe !== 1'b1);
            tx_en <= 1;
            txd   <= (raw && i < 2) ? (i ? 4'h1 : 4'h8) : v;
            tx_er <= raw ? (i < 2) : (i == er);
            sent.push_back(v);
        end
        do @(posedge sys_clk); while (nibble_strobe !== 1'b1);
        tx_en <= 0;
        tx_er <= 0;
        txd   <= ~v;
    endtask
endmodule // fepc_mac_model
`default_nettype wire

//--- testbench/fast_ethernet_pcs_coding_tb.sv
// Purpose: Self-checking bench for the coding block
// Assumes: Serial output looped back to serial input
// Notes:   Energy filter counts shortened to 20 and 10
`timescale 1ns/1ns
`default_nettype none
`include "fepc_consts.svh"
module fast_ethernet_pcs_coding_tb;
    logic        sys_clk = 0, rst_b = 0, psel = 0, penable = 0, pwrite = 0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, q;
    logic        pready, pslverr, e, nibble_strobe, rx_dv, rx_er, crs, col, line;
    logic        tx_en, tx_er, energy = 0, fiber = 0, link_ok, flag;
    logic        col_seen, crs_seen, er_seen;
    logic        bp_strap = 0;
    logic [3:0]  txd, rxd;
    logic [4:0]  strap = 5'h00;
    int          miscompares = 0, n_compared = 0;
    always #10 sys_clk = ~sys_clk;
    fepc_top #(.ASSERT_CYC(20), .DEASSERT_CYC(10)) DUT (.sys_clk, .rst_b, .psel, .penable,
        .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .tx_en, .tx_er, .txd,
        .nibble_strobe, .rxd, .rx_dv, .rx_er, .crs, .col, .line_rx_in(line),
        .line_tx_out(line), .line_energy_in(energy), .fiber_energy_input(fiber),
        .coding_bypass_strap(bp_strap), .mgmt_addr_strap(strap), .energy_present_flag(flag),
        .link_ok);
    fepc_mac_model mac (.sys_clk, .nibble_strobe, .tx_en, .tx_er, .txd);
    always @(posedge sys_clk) begin
        if (col === 1'b1) col_seen = 1;
        if (crs === 1'b1) crs_seen = 1;
        if (rx_er === 1'b1) er_seen = 1;
    end
    task automatic chk(input logic [31:0] g, input logic [31:0] x);
        n_compared++;
        if (g !== x) begin
            miscompares++;
            $display("MISMATCH t=%0t got %0h exp %0h", $time, g, x);
        end
    endtask
    task summarize;
        $display("compared %0d mismatches %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        psel <= 1; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge sys_clk);
        penable <= 1;
        do @(posedge sys_clk); while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        psel <= 0; penable <= 0;
    endtask
    task automatic frame(input int er, input bit raw);
        logic [3:0] got[$];
        int n;
        col_seen = 0; crs_seen = 0; er_seen = 0;
        fork
            mac.send(12, er, raw);
            begin
                n = 0;
                while (rx_dv !== 1'b1 && n < 400) begin @(posedge sys_clk); n++; end
                while (rx_dv === 1'b1) begin got.push_back(rxd); repeat (5) @(posedge sys_clk); end
            end
        join
        if (er < 0) begin
            chk(got.size(), 20);
            for (int i = 0; i < got.size(); i++)
                chk(got[i], i ? mac.sent[i + 1] : 4'h5);
            chk(er_seen, 0);
        end else chk(er_seen, 1);
        chk(col_seen, 1);
        chk(crs_seen, 1);
        repeat (40) @(posedge sys_clk);
        chk(crs, 0);
    endtask
    initial begin
        void'($urandom(32'h48999b03));
        strap = 5'($urandom);
        repeat (6) @(posedge sys_clk);
        rst_b <= 1;
        apb(0, `FEPC_OFF_CTRL0, 0); chk(q, 0);
        apb(0, `FEPC_OFF_CTRL21, 0); chk(q, 0);
        apb(0, 8'h08, 0); chk({q[30:0], e}, 1);
        $display("register test done");
        energy <= 1;
        repeat (12) @(posedge sys_clk); chk(flag, 0);
        repeat (20) @(posedge sys_clk); chk(flag, 1);
        apb(0, `FEPC_OFF_STATUS, 0); chk(q[1:0], 2'h3);
        energy <= 0;
        repeat (5) @(posedge sys_clk); chk(flag, 1);
        repeat (20) @(posedge sys_clk); chk({flag, link_ok}, 0);
        $display("energy test done");
        energy <= 1;
        repeat (40) @(posedge sys_clk);
        apb(1, `FEPC_OFF_CTRL0, 32'h1 << `FEPC_LOOP_BIT);
        repeat (5) @(posedge sys_clk); chk(link_ok, 0);
        apb(1, `FEPC_OFF_CTRL21, 32'h8); energy <= 0;
        repeat (40) @(posedge sys_clk); chk(link_ok, 1);
        apb(1, `FEPC_OFF_CTRL0, 0);
        $display("loopback test done");
        for (int m = 0; m < 6; m++) begin
            apb(1, `FEPC_OFF_CTRL21,
                m == 1 ? 32'h4 : m == 2 ? 32'h1 : m == 4 ? 32'h2 : 32'h0);
            energy   <= (m != 2);
            fiber    <= (m == 2);
            bp_strap <= (m == 5);
            repeat (150) @(posedge sys_clk);
            chk(link_ok, 1);
            apb(0, `FEPC_OFF_STATUS, 0);
            chk(q[4], m > 3);
            if (m == 1) repeat (10) begin
                e = line; @(posedge sys_clk); chk(line ^ e, 1);
            end
            frame(m == 3 ? 10 : -1, m > 3);
            $display("frame test %0d done", m);
        end
        summarize;
    end
    initial begin
        #400000;
        miscompares++;
        summarize;
    end
    // Scrambled idle after reset follows the key from the strap seed
    initial begin
        logic [10:0] s;
        logic        p;
        logic        k;
        @(posedge rst_b);
        repeat (4) @(posedge sys_clk);
        s = {`FEPC_SEED_TOP, strap};
        p = line;
        repeat (20) begin
            @(posedge sys_clk);
            k = ~(s[10] ^ s[8]);
            chk(line ^ p, k);
            p = line;
            s = {s[9:0], s[10] ^ s[8]};
        end
    end
endmodule // fast_ethernet_pcs_coding_tb
`default_nettype wire
